/* File: fpls_map.svh */
// Register map, field positions, reset values and cycle counts of the FP stacking unit
`ifndef FPLS_MAP_SVH
`define FPLS_MAP_SVH
`define FPLS_FPCC_ADDR 32'hE000_EF34
`define FPLS_STAT_ADDR 32'hE000_EF38
`define FPLS_DSE_BIT 30
`define FPLS_PEND_BIT 0
`define FPLS_FPCC_RST 32'h4000_0000
`define FPLS_DIV_CYC 4'hE
`define FPLS_ISR_MIN 5'h0C
`define FPLS_CORE_LAST 5'h07
`define FPLS_FP_FIRST 5'h08
`define FPLS_FP_LAST 5'h18
`define FPLS_FRAME_BYTES 32'h0000_0068
`endif

/* File: fpls_pkg.sv */
// Types shared by the FP stacking unit
package fpls_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH, ST_ENTRY_WAIT, ST_ISR, ST_RET_WAIT, ST_POP
  } fpls_state_e;
  typedef struct packed {
    logic valid;
    logic sqrt;
    logic [4:0] dest;
  } fpls_issue_s;
  typedef struct packed {
    logic valid;
    logic sqrt;
    logic [4:0] dest;
    logic [31:0] data;
  } fpls_wb_s;
  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpls_mem_s;
endpackage

/* File: fpls_core.sv */
// FP divide completion and deferred FP context stacking around exception entry and return
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "fpls_map.svh"
module fpls_core import fpls_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Divide issue and writeback
  input wire fpls_issue_s issue,
  input wire logic [31:0] divResult,
  output fpls_wb_s wb,
  output logic divBusy,
  // Core events
  input wire logic excTake,
  input wire logic [31:0] stackPtr,
  input wire logic fpUse,
  input wire logic excRet,
  output logic isrStart,
  output logic fpStall,
  output logic retDone,
  // Context read port and stack memory
  output logic [4:0] ctxIdx,
  input wire logic [31:0] ctxData,
  output fpls_mem_s mem,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output logic restoreValid,
  output logic [4:0] restoreIdx,
  output logic [31:0] restoreData
);

  function automatic logic [31:0] stackAddr(input logic [31:0] base, input logic [4:0] idx);
    stackAddr = base + {25'h000_0000, idx, 2'b00};
  endfunction

  // Register file
  logic dseReg, dseNext;
  logic [31:0] rdReg, rdNext;
  logic waitReg, waitNext;
  // Divider
  logic [3:0] divCntReg, divCntNext;
  logic busyReg, busyNext;
  fpls_issue_s opReg, opNext;
  fpls_wb_s wbReg, wbNext;
  // Sequencer
  fpls_state_e stReg, stNext;
  logic [4:0] idxReg, idxNext, lastReg, lastNext, ctxReg, ctxNext;
  logic [4:0] entCntReg, entCntNext;
  logic entryReg, entryNext, lazyEntReg, lazyEntNext, pendReg, pendNext;
  logic [31:0] baseReg, baseNext;
  fpls_mem_s memReg, memNext;
  logic isrReg, isrNext, stallReg, stallNext, retReg, retNext;
  logic rvReg, rvNext;
  logic [4:0] riReg, riNext;
  logic [31:0] rdatReg, rdatNext;
  logic busAcc, fpccWr;

  assign busAcc = (avs_read || avs_write) && !waitReg;
  assign fpccWr = busAcc && avs_write && avs_address == `FPLS_FPCC_ADDR;

  // One wait cycle per access; unmapped reads give zero, unmapped writes are dropped
  always_comb begin
    dseNext = dseReg;
    rdNext = rdReg;
    waitNext = 1'b1;
    if ((avs_read || avs_write) && waitReg) begin
      waitNext = 1'b0;
      rdNext = 32'h0000_0000;
      if (avs_address == `FPLS_FPCC_ADDR) begin
        rdNext[`FPLS_DSE_BIT] = dseReg;
        rdNext[`FPLS_PEND_BIT] = pendReg;
      end else if (avs_address == `FPLS_STAT_ADDR) begin
        rdNext[0] = busyReg;
        rdNext[1] = pendReg;
        rdNext[2] = stallReg;
        rdNext[7:4] = divCntReg;
      end
    end
    if (fpccWr && avs_byteenable[3]) begin
      dseNext = avs_writedata[`FPLS_DSE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dseReg <= 1'b1;
      rdReg <= 32'h0000_0000;
      waitReg <= 1'b1;
    end else begin
      dseReg <= dseNext;
      rdReg <= rdNext;
      waitReg <= waitNext;
    end
  end

  // Divider runs on its own; the sequencer never cancels it
  always_comb begin
    divCntNext = divCntReg;
    busyNext = busyReg;
    opNext = opReg;
    wbNext = wbReg;
    wbNext.valid = 1'b0;
    if (busyReg) begin
      divCntNext = divCntReg + 4'h1;
      if (divCntReg == `FPLS_DIV_CYC - 4'h1) begin
        busyNext = 1'b0;
        wbNext = '{valid: 1'b1, sqrt: opReg.sqrt, dest: opReg.dest, data: divResult};
      end
    end else if (issue.valid) begin
      busyNext = 1'b1;
      divCntNext = 4'h1;
      opNext = issue;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      divCntReg <= 4'h0;
      busyReg <= 1'b0;
      opReg <= '0;
      wbReg <= '0;
    end else begin
      divCntReg <= divCntNext;
      busyReg <= busyNext;
      opReg <= opNext;
      wbReg <= wbNext;
    end
  end

  // Stacking sequencer
  always_comb begin
    stNext = stReg;
    idxNext = idxReg;
    lastNext = lastReg;
    ctxNext = ctxReg;
    entCntNext = entCntReg;
    entryNext = entryReg;
    lazyEntNext = lazyEntReg;
    pendNext = pendReg;
    baseNext = baseReg;
    memNext = memReg;
    isrNext = 1'b0;
    retNext = 1'b0;
    rvNext = 1'b0;
    riNext = riReg;
    rdatNext = rdatReg;
    if (stReg == ST_PUSH || stReg == ST_ENTRY_WAIT) begin
      if (entCntReg != 5'h1F) begin
        entCntNext = entCntReg + 5'h01;
      end
    end
    case (stReg)
      ST_IDLE: begin
        if (excTake) begin
          stNext = ST_PUSH;
          baseNext = stackPtr - `FPLS_FRAME_BYTES;
          idxNext = 5'h00;
          ctxNext = 5'h00;
          entryNext = 1'b1;
          entCntNext = 5'h01;
          lazyEntNext = dseReg;
          pendNext = dseReg;
          lastNext = dseReg ? `FPLS_CORE_LAST : `FPLS_FP_LAST;
        end
      end
      ST_PUSH, ST_POP: begin
        if (memReg.req && memAck) begin
          if (stReg == ST_POP) begin
            rvNext = 1'b1;
            riNext = idxReg;
            rdatNext = memRdata;
          end
          if (idxReg == lastReg) begin
            memNext.req = 1'b0;
            if (stReg == ST_POP) begin
              stNext = ST_IDLE;
              retNext = 1'b1;
            end else begin
              stNext = entryReg ? ST_ENTRY_WAIT : ST_ISR;
              if (!entryReg) begin
                pendNext = 1'b0;
              end
            end
          end else begin
            idxNext = idxReg + 5'h01;
            memNext.addr = stackAddr(baseReg, idxReg + 5'h01);
            memNext.wdata = ctxData;
            memNext.req = !(idxReg + 5'h01 >= `FPLS_FP_FIRST && busyReg);
            // Held-back word must be presented again when the push resumes
            ctxNext = memNext.req ? idxReg + 5'h02 : idxReg + 5'h01;
          end
        end else if (!memReg.req && !(idxReg >= `FPLS_FP_FIRST && busyReg)) begin
          memNext = '{req: 1'b1, write: stReg == ST_PUSH, addr: stackAddr(baseReg, idxReg),
                      wdata: ctxData};
          ctxNext = idxReg + 5'h01;
        end
      end
      ST_ENTRY_WAIT: begin
        if (entCntNext >= `FPLS_ISR_MIN) begin
          stNext = ST_ISR;
          isrNext = 1'b1;
          entryNext = 1'b0;
        end
      end
      ST_ISR: begin
        if (excRet) begin
          stNext = ST_RET_WAIT;
          idxNext = 5'h00;
          ctxNext = 5'h00;
          lastNext = pendReg ? `FPLS_CORE_LAST : `FPLS_FP_LAST;
        end else if (fpUse && pendReg) begin
          stNext = ST_PUSH;
          idxNext = `FPLS_FP_FIRST;
          ctxNext = `FPLS_FP_FIRST;
          lastNext = `FPLS_FP_LAST;
        end
      end
      ST_RET_WAIT: begin
        if (!busyReg) begin
          stNext = ST_POP;
          pendNext = 1'b0;
        end
      end
      default: begin
        stNext = ST_IDLE;
      end
    endcase
    stallNext = stNext == ST_PUSH && !entryNext;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stReg <= ST_IDLE;
      idxReg <= 5'h00;
      lastReg <= 5'h00;
      ctxReg <= 5'h00;
      entCntReg <= 5'h00;
      entryReg <= 1'b0;
      lazyEntReg <= 1'b0;
      pendReg <= 1'b0;
      baseReg <= 32'h0000_0000;
      memReg <= '0;
      isrReg <= 1'b0;
      stallReg <= 1'b0;
      retReg <= 1'b0;
      rvReg <= 1'b0;
      riReg <= 5'h00;
      rdatReg <= 32'h0000_0000;
    end else begin
      stReg <= stNext;
      idxReg <= idxNext;
      lastReg <= lastNext;
      ctxReg <= ctxNext;
      entCntReg <= entCntNext;
      entryReg <= entryNext;
      lazyEntReg <= lazyEntNext;
      pendReg <= pendNext;
      baseReg <= baseNext;
      memReg <= memNext;
      isrReg <= isrNext;
      stallReg <= stallNext;
      retReg <= retNext;
      rvReg <= rvNext;
      riReg <= riNext;
      rdatReg <= rdatNext;
    end
  end

  assign avs_readdata = rdReg;
  assign avs_waitrequest = waitReg;
  assign wb = wbReg;
  assign divBusy = busyReg;
  assign isrStart = isrReg;
  assign fpStall = stallReg;
  assign retDone = retReg;
  assign ctxIdx = ctxReg;
  assign mem = memReg;
  assign restoreValid = rvReg;
  assign restoreIdx = riReg;
  assign restoreData = rdatReg;

  AST_DIV_LAT: assert property (@(posedge mclk) disable iff (rst)
    !busyReg && issue.valid |-> ##14 wbReg.valid)
    else $error("divide result not written 14 cycles after issue");
  AST_DIV_CAUSE: assert property (@(posedge mclk) disable iff (rst)
    wbReg.valid |-> $past(busyReg) && $past(divCntReg) == 4'hD)
    else $error("divide writeback without matching issue");
  AST_NO_ABORT: assert property (@(posedge mclk) disable iff (rst)
    busyReg && (excTake || stReg != ST_IDLE) |=> busyReg || wbReg.valid)
    else $error("divide aborted by exception entry");
  AST_LAZY_SKIP: assert property (@(posedge mclk) disable iff (rst)
    memReg.req && memReg.write && entryReg && idxReg >= 5'h08 |-> !lazyEntReg)
    else $error("FP words stacked at entry with deferral on");
  AST_RST_EN: assert property (@(posedge mclk)
    rst |=> dseReg)
    else $error("deferral enable not set after reset");
  AST_ISR_MIN: assert property (@(posedge mclk) disable iff (rst)
    stReg == ST_IDLE && excTake |=> !isrReg [*8] ##1 !isrReg [*3])
    else $error("handler started sooner than 12 cycles after entry");
  AST_FPCC_WR: assert property (@(posedge mclk) disable iff (rst)
    fpccWr && avs_byteenable[3] |=> dseReg == $past(avs_writedata[30]))
    else $error("deferral enable write not taken");
  AST_COMMIT: assert property (@(posedge mclk) disable iff (rst)
    busyReg && divCntReg == 4'hD |=> wbReg.valid && !busyReg)
    else $error("divide result not committed");
  AST_FP_STALL: assert property (@(posedge mclk) disable iff (rst)
    memReg.req && idxReg >= 5'h08 || stReg == ST_POP |-> !busyReg)
    else $error("FP state moved while divide outstanding");

endmodule // fpls_core

/* File: fpls_mem_model.sv */
// Stack memory model answering the unit's push and pop requests
`timescale 1ns/1ns
module fpls_mem_model import fpls_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Stack port
  input wire fpls_mem_s mem,
  output logic memAck,
  output logic [31:0] memRdata,
  // Bench controls
  input wire logic [1:0] waitCyc,
  output int wrCount
);
  // Only 32 words kept, indexed by address bits 6:2 with wrap, so one frame must not exceed 128 bytes
  logic [31:0] ram [32];
  logic [31:0] lastRd;
  logic [1:0] waited;
  assign memAck = mem.req && waited == waitCyc;
  // Idle bus shows the inverse of the last word, so stale data never passes
  assign memRdata = (memAck && !mem.write) ? ram[mem.addr[6:2]] : ~lastRd;
  always @(posedge mclk) begin
    if (rst) begin
      waited <= 2'h0;
      wrCount <= 0;
      lastRd <= 32'h0000_0000;
    end else if (memAck) begin
      waited <= 2'h0;
      if (mem.write) begin
        ram[mem.addr[6:2]] <= mem.wdata;
        wrCount <= wrCount + 1;
      end else begin
        lastRd <= memRdata;
      end
    end else if (mem.req) begin
      waited <= waited + 2'h1;
    end
  end
endmodule // fpls_mem_model

/* File: fpls_core_tb.sv */
// Self-checking testbench of the FP divide completion and deferred stacking unit
`timescale 1ns/1ns
`include "fpls_map.svh"
module fpls_core_tb import fpls_pkg::*;;
  logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_address = 32'h0000_0000, avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] divResult = 32'h3FC0_1234, stackPtr = 32'h2000_1000;
  logic excTake = 1'b0, fpUse = 1'b0, excRet = 1'b0;
  logic [1:0] waitCyc = 2'h0;
  fpls_issue_s issue = '0;
  fpls_wb_s wb;
  fpls_mem_s mem;
  logic [31:0] avs_readdata, ctxData, memRdata, restoreData;
  logic avs_waitrequest, divBusy, isrStart, fpStall, retDone, memAck, restoreValid;
  logic [4:0] ctxIdx, restoreIdx;
  int cyc = 0, t0, wbAt, rstAt, rstCnt, wrCount, miscompares = 0, cmpCount = 0;

  always #25 mclk = ~mclk;
  assign ctxData = 32'h5A00_0000 | 32'(ctxIdx);

  fpls_core i_dut (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .issue, .divResult, .wb, .divBusy,
    .excTake, .stackPtr, .fpUse, .excRet, .isrStart, .fpStall, .retDone, .ctxIdx,
    .ctxData, .mem, .memAck, .memRdata, .restoreValid, .restoreIdx, .restoreData);
  fpls_mem_model i_mem (.mclk, .rst, .mem, .memAck, .memRdata, .waitCyc, .wrCount);

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    cmpCount++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // No wait limit here; the bench timeout ends a hung access
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  // Latency counts edges from the edge that took the request
  task automatic waitEv(input int k, output int lat);
    logic s;
    do begin
      @(posedge mclk);
      s = k == 0 ? isrStart : k == 1 ? wb.valid : k == 2 ? retDone : !fpStall;
    end while (s !== 1'b1);
    lat = cyc - t0;
  endtask

  task automatic excRun(input bit dv, input logic [1:0] ws, input bit fp, input int n);
    int lat, w0;
    w0 = wrCount;
    rstCnt = 0;
    wbAt = 0;
    waitCyc <= ws;
    excTake <= 1'b1;
    if (dv) issue <= '{1'b1, 1'b0, 5'h02};
    t0 = cyc + 1;
    @(posedge mclk);
    excTake <= 1'b0;
    issue <= '0;
    waitEv(0, lat);
    chk("isr cycles", lat >= 12 && (ws != 0 || n != 8 || lat == 12), 1);
    if (fp) begin
      fpUse <= 1'b1;
      @(posedge mclk);
      fpUse <= 1'b0;
      @(posedge mclk);
      chk("fp stall", fpStall, 1);
      waitEv(3, lat);
    end
    excRet <= 1'b1;
    @(posedge mclk);
    excRet <= 1'b0;
    waitEv(2, lat);
    @(posedge mclk);
    chk("stack writes", wrCount - w0, n);
    chk("pops", rstCnt, n);
    if (dv) chk("wb cycles", wbAt - t0, 14);
    if (dv) chk("wb before pop", wbAt < rstAt, 1);
    $display("test exception n=%0d done", n);
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wb.valid === 1'b1) wbAt = cyc;
    if (restoreValid === 1'b1) begin
      if (rstCnt == 0) rstAt = cyc;
      chk("pop data", restoreData, 32'h5A00_0000 | rstCnt);
      chk("pop index", restoreIdx, rstCnt);
      rstCnt++;
    end
    if (cyc == 2000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    logic [31:0] q;
    int lat;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, `FPLS_FPCC_ADDR, 32'h0000_0000, q);
    chk("ctx ctrl", q, 32'h4000_0000);
    bus(1'b0, 32'hE000_EF30, 32'h0000_0000, q);
    chk("unmapped", q, 0);
    $display("test registers done");
    issue <= '{1'b1, 1'b1, 5'h09};
    t0 = cyc + 1;
    @(posedge mclk);
    issue <= '0;
    @(posedge mclk);
    chk("div busy", divBusy, 1);
    waitEv(1, lat);
    chk("div cycles", lat, 14);
    chk("div result", {wb.sqrt, wb.dest, wb.data}, {6'h29, divResult});
    chk("div idle", divBusy, 0);
    bus(1'b0, `FPLS_STAT_ADDR, 32'h0000_0000, q);
    chk("status", q, 32'h0000_00E0);
    $display("test divide done");
    // Tiny handler returns before the divide ends
    excRun(1'b1, 2'h0, 1'b0, 8);
    excRun(1'b0, 2'h2, 1'b1, 25);
    bus(1'b1, `FPLS_FPCC_ADDR, 32'h0000_0000, q);
    bus(1'b0, `FPLS_FPCC_ADDR, 32'h0000_0000, q);
    chk("enable off", q, 0);
    excRun(1'b1, 2'h0, 1'b0, 25);
    bus(1'b1, `FPLS_FPCC_ADDR, 32'h4000_0000, q);
    excRun(1'b0, 2'h1, 1'b0, 8);
    final_report();
  end
endmodule // fpls_core_tb
